// File: hw/ascw_pkg.sv
package ascw_pkg;

  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int WORD_W   = 16;
  localparam int FLAG_BIT = 15;
  localparam int RW_BIT   = 14;
  localparam int DEV_HI   = 13;
  localparam int DEV_LO   = 11;
  localparam int IDX_HI   = 10;
  localparam int IDX_LO   = 8;
  localparam int DATA_HI  = 7;

  // ----------------------------------------------------------------
  // Register indices and reset value
  // ----------------------------------------------------------------
  localparam int         NUM_REGS = 7;
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_CLK  = 3'h1;
  localparam logic [2:0] IDX_REF  = 3'h2;
  localparam logic [2:0] IDX_GP12 = 3'h3;
  localparam logic [2:0] IDX_CHAN = 3'h6;
  localparam logic [7:0] REG_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_OP_BIT   = 0;
  localparam int MODE_MIX_BIT  = 1;
  localparam int MODE_LOOP_BIT = 3;
  localparam int MODE_CNT_LSB  = 4;
  localparam int MODE_SRST_BIT = 7;
  localparam int CLK_DR_LSB    = 0;
  localparam int CLK_SCD_LSB   = 2;
  localparam int CLK_MCD_LSB   = 4;
  localparam int CLK_ECHO_BIT  = 7;
  localparam int REF_ALL_BIT   = 0;
  localparam int REF_PWR_BIT   = 5;
  localparam int REF_OUT_BIT   = 6;
  localparam int GP_LO_GS_LSB  = 0;
  localparam int GP_LO_PWR_BIT = 3;
  localparam int GP_HI_GS_LSB  = 4;
  localparam int GP_HI_PWR_BIT = 7;
  localparam int CH_SEL_LSB    = 0;
  localparam int CH_MODRST_BIT = 6;
  localparam int CH_SE_BIT     = 7;

  // Writable bits; reserved positions always read back as zero
  localparam logic [7:0] MODE_WMASK = 8'hFB;
  localparam logic [7:0] REF_WMASK  = 8'h61;
  localparam logic [7:0] FULL_WMASK = 8'hFF;

  // ----------------------------------------------------------------
  // Timing counts, in internal master clock cycles
  // ----------------------------------------------------------------
  localparam int RESET_TICK_CYC = 4;

  function automatic logic [7:0] ascw_wmask(input logic [2:0] idx);
    if (idx == IDX_MODE) return MODE_WMASK;
    if (idx == IDX_REF) return REF_WMASK;
    return FULL_WMASK;
  endfunction : ascw_wmask

  // Master divider: codes above 4 fall back to divide by one
  function automatic logic [2:0] ascw_mdiv(input logic [2:0] code);
    return (code <= 3'h4) ? 3'(code + 3'h1) : 3'h1;
  endfunction : ascw_mdiv

  function automatic logic [3:0] ascw_sdiv(input logic [1:0] code);
    return 4'(4'h8 >> code);
  endfunction : ascw_sdiv

  function automatic logic [11:0] ascw_ddiv(input logic [1:0] code);
    return 12'(12'h800 >> code);
  endfunction : ascw_ddiv

endpackage : ascw_pkg

// File: hw/ascw_buf_if.sv
`timescale 1ns/1ns
interface ascw_buf_if #(
  parameter int W = 16
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport user (
    output in_valid, in_data, out_ready,
    input  in_ready, out_valid, out_data
  );
  modport buffer (
    input  in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
endinterface : ascw_buf_if

// File: hw/ascw_fifo.sv
`timescale 1ns/1ns
module ascw_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Both sides of the buffer
  ascw_buf_if.buffer bif
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("ascw_fifo: DEPTH must be at least 2");
  end

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  // Full and empty come straight from the occupancy count
  assign bif.in_ready  = (cnt_q != CW'(DEPTH));
  assign bif.out_valid = (cnt_q != '0);
  assign bif.out_data  = mem_q[rd_q];
  assign push = bif.in_valid && bif.in_ready;
  assign pop  = bif.out_valid && bif.out_ready;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : nxt

  // Storage, written only on an accepted push
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= bif.in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= nxt(wr_q);
      if (pop) rd_q <= nxt(rd_q);
      if (push && !pop) cnt_q <= CW'(cnt_q + 1'b1);
      else if (pop && !push) cnt_q <= CW'(cnt_q - 1'b1);
    end
  end

  a_no_overflow : assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q <= CW'(DEPTH))
    else $error("buffer count above depth");

endmodule : ascw_fifo

// File: hw/ascw_top.sv
// Contract
// - Bit 15 flags a control word
// - Addressed write stores data in selected register
// - Addressed read returns register in data field
// - Act only when device address is zero
// - Nonzero address: decrement and forward word
// - Bits 10 to 8 select register
// - Bits 7 to 0 carry register data
// - Mode bit 0 selects program or data
// - Mode bit 1 enables mixed mode
// - Mode bit 3 enables serial loop-back
// - Mode bits 6 to 4 give cascade count
// - Mode bit 7 starts software reset
// - Clock bits 1 to 0 decimation rate
// - Clock bits 3 to 2 serial divider
// - Clock bits 6 to 4 master divider
// - Clock bit 7 enables control echo
// - Reference bit 0 global power up
// - Reference bits 5, 6 power and pin
// - Gain registers hold two 3-bit gains
// - Gain registers bits 3, 7 converter power
// - Channel selects, modulator reset, single-ended
// - Master divider codes give 1 to 5
// - Serial divider gives 8, 4, 2, 1
// - Decimation gives 2048 down to 256
// - Resets clear registers, last four cycles
`timescale 1ns/1ns
module ascw_top import ascw_pkg::*; #(
  parameter int EXT_CLK_PRE = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial link pins
  input  wire logic        ser_in,
  input  wire logic        ser_in_fs,
  output logic             ser_out,
  output logic             ser_out_fs,
  output logic             serial_bit_clock,
  // Timing ticks and reset status
  output logic             internal_master_clock,
  output logic             sample_tick,
  output logic             reset_busy,
  // Mode and cascade controls
  output logic             operating_mode_bit,
  output logic             mixed_mode_enable,
  output logic             serial_loopback_enable,
  output logic [2:0]       cascade_count,
  output logic             control_echo_enable,
  // Power and reference controls
  output logic             global_power_up,
  output logic             reference_power,
  output logic             reference_output_pin,
  // Channel controls
  output logic [17:0]      chan_gain_select,
  output logic [5:0]       chan_converter_power,
  output logic [5:0]       chan_select_bit,
  output logic             modulator_reset,
  output logic             single_ended_enable
);

  if (EXT_CLK_PRE < 2 || EXT_CLK_PRE > 12) begin : g_bad_pre
    $error("ascw_top: EXT_CLK_PRE must lie in 2..12");
  end

  typedef enum logic {ST_RST, ST_RUN} ascw_state_t;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]   regs_q [NUM_REGS];
  ascw_state_t  st_q;
  logic [2:0]   rst_cnt_q;

  function automatic logic [7:0] reg_rd(input logic [2:0] idx);
    return (idx < 3'(NUM_REGS)) ? regs_q[idx] : 8'h00;
  endfunction : reg_rd

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  logic [7:0]  dm_len;
  logic [7:0]  dm_cnt_q;
  logic        dm_tick;
  logic [8:0]  bit_len;
  logic [8:0]  bit_half;
  logic [8:0]  bit_cnt_q;
  logic        rise_pt;
  logic        fall_pt;
  logic [11:0] dec_len;
  logic [11:0] dec_cnt_q;
  logic        sclk_q;
  logic        samp_q;

  // Internal master tick every EXT_CLK_PRE times the divider ratio
  assign dm_len = 8'(EXT_CLK_PRE) *
                  8'(ascw_mdiv(regs_q[IDX_CLK][CLK_MCD_LSB +: 3]));
  assign dm_tick = (dm_cnt_q >= dm_len - 8'h01);
  // Bit period in clk cycles; shortest is two, so the pin can toggle
  assign bit_len = 9'(dm_len) *
                   9'(ascw_sdiv(regs_q[IDX_CLK][CLK_SCD_LSB +: 2]));
  assign bit_half = bit_len >> 1;
  assign rise_pt  = (bit_cnt_q == 9'h000);
  assign fall_pt  = (bit_cnt_q == bit_half);
  assign dec_len = ascw_ddiv(regs_q[IDX_CLK][CLK_DR_LSB +: 2]);

  // Master divider count; compare with >= so a new ratio never hangs it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dm_cnt_q <= 8'h00;
    else if (dm_tick) dm_cnt_q <= 8'h00;
    else dm_cnt_q <= 8'(dm_cnt_q + 8'h01);
  end

  // Bit clock count and pin, high in the first half of each bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 9'h000;
      sclk_q    <= 1'b0;
    end else begin
      if (bit_cnt_q >= bit_len - 9'h001) bit_cnt_q <= 9'h000;
      else bit_cnt_q <= 9'(bit_cnt_q + 9'h001);
      sclk_q <= (bit_cnt_q < bit_half);
    end
  end

  // Sample tick from the decimation divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_q <= 12'h000;
      samp_q    <= 1'b0;
    end else begin
      samp_q <= 1'b0;
      if (dm_tick) begin
        if (dec_cnt_q >= dec_len - 12'h001) begin
          dec_cnt_q <= 12'h000;
          samp_q    <= 1'b1;
        end else begin
          dec_cnt_q <= 12'(dec_cnt_q + 12'h001);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------
  logic [1:0]  din_sync_q;
  logic [1:0]  fs_sync_q;
  logic        din;
  logic        fs;
  logic [14:0] rx_sh_q;
  logic [3:0]  rx_cnt_q;
  logic        rx_act_q;
  logic [15:0] rx_word_q;
  logic        rx_vld_q;
  logic        rx_done;
  logic        take;

  // Pins cross in through two flops; only the second one is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din_sync_q <= 2'h0;
      fs_sync_q  <= 2'h0;
    end else begin
      din_sync_q <= {din_sync_q[0], ser_in};
      fs_sync_q  <= {fs_sync_q[0], ser_in_fs};
    end
  end
  assign din = din_sync_q[1];
  assign fs  = fs_sync_q[1];
  assign rx_done = fall_pt && rx_act_q && (rx_cnt_q == 4'hF);

  // Shift in on the falling point; a frame sync marks bit 15
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q  <= 15'h0000;
      rx_cnt_q <= 4'h0;
      rx_act_q <= 1'b0;
    end else if (fall_pt) begin
      if (rx_act_q) begin
        rx_sh_q  <= {rx_sh_q[13:0], din};
        rx_cnt_q <= 4'(rx_cnt_q + 4'h1);
        rx_act_q <= (rx_cnt_q != 4'hF);
      end else if (fs) begin
        rx_sh_q  <= {14'h0000, din};
        rx_cnt_q <= 4'h1;
        rx_act_q <= 1'b1;
      end
    end
  end

  // Word holding; a new word wins over consumption of the old
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_q <= 16'h0000;
      rx_vld_q  <= 1'b0;
    end else if (rx_done) begin
      rx_word_q <= {rx_sh_q, din};
      rx_vld_q  <= 1'b1;
    end else if (take) begin
      rx_vld_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Word interpreter
  // ----------------------------------------------------------------
  ascw_buf_if #(.W(WORD_W)) bif ();

  logic [2:0]  dev;
  logic [2:0]  ridx;
  logic [7:0]  rdat;
  logic        flag;
  logic        rd_req;
  logic        op_mode;
  logic        mix_mode;
  logic        loop_on;
  logic        echo_on;
  logic        accept;
  logic        need_push;
  logic        wr_en;
  logic        srst_go;
  logic [15:0] push_word;
  logic [15:0] out_word_q;
  logic        out_vld_q;

  assign dev    = rx_word_q[DEV_HI:DEV_LO];
  assign ridx   = rx_word_q[IDX_HI:IDX_LO];
  assign rdat   = rx_word_q[DATA_HI:0];
  assign flag   = rx_word_q[FLAG_BIT];
  assign rd_req = rx_word_q[RW_BIT];
  assign op_mode  = regs_q[IDX_MODE][MODE_OP_BIT];
  assign mix_mode = regs_q[IDX_MODE][MODE_MIX_BIT];
  assign loop_on  = regs_q[IDX_MODE][MODE_LOOP_BIT];
  assign echo_on  = regs_q[IDX_CLK][CLK_ECHO_BIT];

  // Control only with the flag set, and never in pure data mode
  assign accept = !loop_on && flag && (!op_mode || mix_mode);
  // Loop-back returns every word untouched, without acting on it
  assign need_push = loop_on ||
                     (accept && ((dev != 3'h0) || rd_req || echo_on));
  // Stall while the output slot is still waiting on the buffer
  assign take = rx_vld_q && (!out_vld_q || bif.in_ready);
  assign wr_en = take && (st_q == ST_RUN) && accept &&
                 (dev == 3'h0) && !rd_req;
  assign srst_go = wr_en && (ridx == IDX_MODE) &&
                   rdat[MODE_SRST_BIT];

  // Output word: forwarded, read back or echoed
  always_comb begin
    push_word = rx_word_q;
    if (!loop_on) begin
      if (dev != 3'h0) begin
        push_word[DEV_HI:DEV_LO] = 3'(dev - 3'h1);
      end else if (rd_req) begin
        push_word[DATA_HI:0] = reg_rd(ridx);
      end
    end
  end

  // Output slot into the buffer; words taken during reset are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_word_q <= 16'h0000;
      out_vld_q  <= 1'b0;
    end else if (take) begin
      out_word_q <= push_word;
      out_vld_q  <= need_push && (st_q == ST_RUN);
    end else if (bif.in_ready) begin
      out_vld_q <= 1'b0;
    end
  end
  assign bif.in_valid = out_vld_q;
  assign bif.in_data  = out_word_q;

  // Reset sequencing: four internal master cycles after either reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_RST;
      rst_cnt_q <= 3'h0;
    end else if (srst_go) begin
      st_q      <= ST_RST;
      rst_cnt_q <= 3'h0;
    end else if (st_q == ST_RST && dm_tick) begin
      if (rst_cnt_q == 3'(RESET_TICK_CYC - 1)) st_q <= ST_RUN;
      rst_cnt_q <= 3'(rst_cnt_q + 3'h1);
    end
  end

  // Register writes; reserved bits are masked to zero on the way in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= REG_RST;
    end else if (srst_go) begin
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= REG_RST;
    end else if (wr_en && ridx < 3'(NUM_REGS)) begin
      regs_q[ridx] <= rdat & ascw_wmask(ridx);
    end
  end

  // ----------------------------------------------------------------
  // Output buffer and serial transmitter
  // ----------------------------------------------------------------
  logic [15:0] tx_sh_q;
  logic [3:0]  tx_cnt_q;
  logic        tx_act_q;
  logic        sout_q;
  logic        sout_fs_q;
  logic        tx_free;

  ascw_fifo #(.W(WORD_W), .DEPTH(2)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .bif   (bif)
  );

  // A word may follow the last bit of the previous one directly
  assign tx_free = !tx_act_q || (tx_cnt_q == 4'hF);
  assign bif.out_ready = rise_pt && tx_free;

  // Shift out MSB first on the rising point
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q   <= 16'h0000;
      tx_cnt_q  <= 4'h0;
      tx_act_q  <= 1'b0;
      sout_q    <= 1'b0;
      sout_fs_q <= 1'b0;
    end else if (rise_pt) begin
      if (!tx_free) begin
        sout_q    <= tx_sh_q[14];
        tx_sh_q   <= {tx_sh_q[14:0], 1'b0};
        tx_cnt_q  <= 4'(tx_cnt_q + 4'h1);
        sout_fs_q <= 1'b0;
      end else if (bif.out_valid) begin
        tx_sh_q   <= bif.out_data;
        sout_q    <= bif.out_data[15];
        tx_cnt_q  <= 4'h0;
        tx_act_q  <= 1'b1;
        sout_fs_q <= 1'b1;
      end else begin
        tx_act_q  <= 1'b0;
        sout_q    <= 1'b0;
        sout_fs_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign ser_out    = sout_q;
  assign ser_out_fs = sout_fs_q;
  assign serial_bit_clock      = sclk_q;
  assign internal_master_clock = dm_tick;
  assign sample_tick = samp_q;
  assign reset_busy  = (st_q == ST_RST);
  assign operating_mode_bit     = op_mode;
  assign mixed_mode_enable      = mix_mode;
  assign serial_loopback_enable = loop_on;
  assign cascade_count = regs_q[IDX_MODE][MODE_CNT_LSB +: 3];
  assign control_echo_enable = echo_on;
  assign global_power_up      = regs_q[IDX_REF][REF_ALL_BIT];
  assign reference_power      = regs_q[IDX_REF][REF_PWR_BIT];
  assign reference_output_pin = regs_q[IDX_REF][REF_OUT_BIT];
  assign chan_select_bit = regs_q[IDX_CHAN][CH_SEL_LSB +: 6];
  assign modulator_reset     = regs_q[IDX_CHAN][CH_MODRST_BIT];
  assign single_ended_enable = regs_q[IDX_CHAN][CH_SE_BIT];

  // Each gain register serves a lower and an upper channel
  for (genvar g = 0; g < 3; g++) begin : g_gain
    localparam logic [2:0] IX = 3'(IDX_GP12 + g);
    assign chan_gain_select[6*g +: 3] =
      regs_q[IX][GP_LO_GS_LSB +: 3];
    assign chan_gain_select[6*g+3 +: 3] =
      regs_q[IX][GP_HI_GS_LSB +: 3];
    assign chan_converter_power[2*g]   = regs_q[IX][GP_LO_PWR_BIT];
    assign chan_converter_power[2*g+1] = regs_q[IX][GP_HI_PWR_BIT];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_srst_clears : assert property (
    @(posedge clk) disable iff (!rst_n)
    srst_go |=> (reg_rd(IDX_MODE) == 8'h00 && reg_rd(IDX_CHAN) == 8'h00 &&
                 st_q == ST_RST))
    else $error("soft reset did not clear registers");

  a_reset_len : assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == ST_RST && dm_tick && !srst_go &&
     rst_cnt_q == 3'(RESET_TICK_CYC - 1)) |=> st_q == ST_RUN)
    else $error("reset did not end after four cycles");

  a_reset_min : assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == ST_RUN && $past(st_q) == ST_RST) |->
      $past(rst_cnt_q) == 3'(RESET_TICK_CYC - 1))
    else $error("reset ended early");

  a_fwd_decr : assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && st_q == ST_RUN && accept && dev != 3'h0) |=>
      out_vld_q && out_word_q[DEV_HI:DEV_LO] == 3'($past(dev) - 3'h1) &&
      out_word_q[IDX_HI:0] == $past(rx_word_q[IDX_HI:0]))
    else $error("forwarded address not decremented");

  a_read_back : assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && st_q == ST_RUN && accept && dev == 3'h0 && rd_req) |=>
      out_vld_q && out_word_q[DATA_HI:0] == reg_rd($past(ridx)))
    else $error("read back data wrong");

  a_reg_write : assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_en && !srst_go && ridx == IDX_CHAN) |=>
      regs_q[IDX_CHAN] == $past(rdat))
    else $error("register write lost");

  a_invalid_word : assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && !op_mode && !loop_on && !flag) |=>
      !out_vld_q && $stable(regs_q[IDX_CHAN]) && $stable(regs_q[IDX_REF]))
    else $error("invalid program word acted on");

  a_data_ignore : assert property (
    @(posedge clk) disable iff (!rst_n)
    (op_mode && !mix_mode) |-> !wr_en)
    else $error("write accepted in data mode");

  a_bit_period : assert property (
    @(posedge clk) disable iff (!rst_n)
    (rise_pt && $stable(bit_len)) |=> !rise_pt)
    else $error("bit period shorter than two cycles");

  a_mdiv_wrap : assert property (
    @(posedge clk) disable iff (!rst_n)
    (regs_q[IDX_CLK][CLK_MCD_LSB +: 3] > 3'h4) |->
      dm_len == 8'(EXT_CLK_PRE))
    else $error("high master divider code not divide by one");

endmodule : ascw_top

// File: dv/ascw_host.sv
`timescale 1ns/1ns
// ------
// Host serial port model
// ------
module ascw_host (
  // Clocks
  input wire logic clk,
  input wire logic serial_bit_clock,
  // Device side
  input wire logic ser_out,
  input wire logic ser_out_fs,
  output logic     ser_in,
  output logic     ser_in_fs
);
  logic [15:0] rq[$];
  logic [15:0] sh;
  int          n = 0;

  // Drive after the bit clock rises; the line flips after a frame
  // so that a stale bit is never mistaken for a held one
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(posedge serial_bit_clock);
      @(negedge clk);
      ser_in    = w[i];
      ser_in_fs = (i == 15);
    end
    @(posedge serial_bit_clock);
    @(negedge clk);
    ser_in    = ~ser_in;
    ser_in_fs = 1'b0;
  endtask : send

  // Sample replies mid-bit, at the bit clock fall
  always @(negedge serial_bit_clock) begin
    if (ser_out_fs && n == 0)
      n = 16;
    if (n > 0) begin
      sh = {sh[14:0], ser_out};
      n  = n - 1;
      if (n == 0)
        rq.push_back(sh);
    end
  end

  // Idle line at start
  initial begin
    ser_in    = 1'b0;
    ser_in_fs = 1'b0;
  end
endmodule : ascw_host

// File: dv/ascw_top_tb.sv
`timescale 1ns/1ns
// ------
// Bench
// ------
module ascw_top_tb;
  localparam int PRE = 4; // Master prescale handed to the design
  logic        clk, rst_n, ser_in, ser_in_fs, ser_out, ser_out_fs;
  logic        internal_master_clock, sample_tick;
  logic        serial_bit_clock, reset_busy, operating_mode_bit;
  logic        mixed_mode_enable, serial_loopback_enable;
  logic        control_echo_enable, global_power_up, reference_power;
  logic        reference_output_pin, modulator_reset, single_ended_enable;
  logic [2:0]  cascade_count;
  logic [17:0] chan_gain_select;
  logic [5:0]  chan_converter_power, chan_select_bit;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;

  ascw_top #(.EXT_CLK_PRE(PRE)) ascw_top_i (.clk, .rst_n, .ser_in,
    .ser_in_fs, .ser_out, .ser_out_fs, .serial_bit_clock,
    .internal_master_clock, .sample_tick, .reset_busy,
    .operating_mode_bit, .mixed_mode_enable,
    .serial_loopback_enable, .cascade_count, .control_echo_enable,
    .global_power_up, .reference_power, .reference_output_pin,
    .chan_gain_select, .chan_converter_power, .chan_select_bit,
    .modulator_reset, .single_ended_enable);
  ascw_host host_i (.clk, .serial_bit_clock, .ser_out, .ser_out_fs,
    .ser_in, .ser_in_fs);

  // Clock and hang guard; about 40 words of 1200 cycles, plus gaps
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [17:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // One word in; k 0 expects silence, 1 the reply e, 2 anything
  task automatic xf(input logic [15:0] w, input int k, logic [15:0] e);
    host_i.send(w);
    repeat (20) @(posedge serial_bit_clock);
    @(negedge clk);
    if (k == 1)
      chk("reply", host_i.rq.size() > 0 ? host_i.rq[0] : 'x, e);
    if (k == 0)
      chk("silent", 18'(host_i.rq.size()), 0);
    host_i.rq.delete();
  endtask : xf

  // Pin reset, then bounded wait for the reset sequence
  task automatic pin_rst();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 200 && reset_busy !== 1'b0; i++)
      @(negedge clk);
    chk("busy", reset_busy, 0);
    @(posedge serial_bit_clock);
  endtask : pin_rst

  task automatic t_regs();
    for (int i = 0; i < 8; i++)
      xf({5'h18, 3'(i), 8'h00}, 1, {5'h18, 3'(i), 8'h00});
    xf(16'h8261, 0, 0);
    xf(16'h83A5, 0, 0);
    xf(16'h845A, 0, 0);
    xf(16'h853C, 0, 0);
    xf(16'h86C3, 0, 0);
    xf(16'h87FF, 0, 0);
    xf(16'h8070, 0, 0);
    chk("gain", chan_gain_select, {3'h3, 3'h4, 3'h5, 3'h2, 3'h2, 3'h5});
    chk("pwr", chan_converter_power, 6'h16);
    chk("sel", {modulator_reset, single_ended_enable, chan_select_bit},
      8'hC3);
    chk("ref", {global_power_up, reference_power, reference_output_pin},
      3'h7);
    chk("cnt", cascade_count, 3'h7);
    xf(16'hC200, 1, 16'hC261);
    xf(16'hC700, 1, 16'hC700);
    xf(16'hC000, 1, 16'hC070);
  endtask : t_regs

  // Cascade forwarding and invalid words
  task automatic t_addr();
    xf(16'h9212, 1, 16'h8A12);
    xf(16'hFA00, 1, 16'hF200);
    xf(16'h03FF, 0, 0);
    xf(16'hC200, 1, 16'hC261);
  endtask : t_addr

  task automatic t_echo_srst();
    xf(16'h8180, 2, 0);
    chk("echo", control_echo_enable, 1);
    xf(16'h8400, 1, 16'h8400);
    xf(16'h8080, 2, 0);
    chk("gain0", chan_gain_select, 0);
    chk("echo0", control_echo_enable, 0);
    xf(16'hC300, 1, 16'hC300);
  endtask : t_echo_srst

  // Mixed mode, then data mode which only a pin reset leaves
  task automatic t_modes();
    xf(16'h8003, 0, 0);
    chk("mix", {operating_mode_bit, mixed_mode_enable}, 2'h3);
    xf(16'h03FF, 0, 0);
    xf(16'h830F, 0, 0);
    xf(16'hC300, 1, 16'hC30F);
    xf(16'h8001, 0, 0);
    chk("data", {operating_mode_bit, mixed_mode_enable}, 2'h2);
    xf(16'hC300, 0, 0);
    pin_rst();
    chk("pgm", operating_mode_bit, 0);
    xf(16'hC300, 1, 16'hC300);
  endtask : t_modes

  task automatic t_loop();
    xf(16'h8008, 0, 0);
    chk("loop", serial_loopback_enable, 1);
    xf(16'h1234, 1, 16'h1234);
    xf(16'h83FF, 1, 16'h83FF);
    pin_rst();
    xf(16'hC300, 1, 16'hC300);
  endtask : t_loop

  // Clocks between pulses: 0 master tick, 1 sample, 2 bit clock rise
  task automatic gap(input int w, input int e);
    int   n;
    logic p, s;
    n = 0;
    p = 1'b1;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
        s = (w == 0) ? internal_master_clock :
            (w == 1) ? sample_tick : (serial_bit_clock && !p);
        p = serial_bit_clock;
      end while (s !== 1'b1 && n < 9000);
    end
    chk("gap", 18'(n), 18'(e));
  endtask : gap

  // Divider ratios seen on the tick pins; registers start cleared
  task automatic t_clk();
    gap(0, PRE);
    xf(16'h8103, 0, 0);
    gap(1, 256 * PRE);
    xf(16'h8128, 0, 0);
    gap(0, 3 * PRE);
    gap(2, 6 * PRE);
    xf(16'h8150, 0, 0);
    gap(0, PRE);
  endtask : t_clk

  // Main sequence
  initial begin
    rst_n = 1'b0;
    pin_rst();
    t_regs();
    t_addr();
    t_echo_srst();
    t_modes();
    t_loop();
    t_clk();
    give_verdict();
  end
endmodule : ascw_top_tb
